// ---- design/asc_pkg.sv ----
package asc_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SEL_A = 12'h004;
  localparam logic [11:0] OFS_SEL_B = 12'h008;
  localparam logic [11:0] OFS_SUM_SEL = 12'h00C;
  localparam logic [11:0] OFS_PRIO = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_WA_SEL = 12'h018;
  localparam logic [11:0] OFS_WA_COND = 12'h01C;
  localparam logic [11:0] OFS_WA_LOW = 12'h020;
  localparam logic [11:0] OFS_WA_UP = 12'h024;
  localparam logic [11:0] OFS_WA_STAT = 12'h028;
  localparam logic [11:0] OFS_WB_CTRL = 12'h02C;
  localparam logic [11:0] OFS_WB_LOW = 12'h030;
  localparam logic [11:0] OFS_WB_UP = 12'h034;
  localparam logic [11:0] OFS_WB_STAT = 12'h038;
  localparam logic [11:0] OFS_WIN_MON = 12'h03C;
  localparam logic [11:0] OFS_RING_EN = 12'h040;
  localparam logic [11:0] OFS_RING_PTR = 12'h044;
  localparam logic [11:0] OFS_DUP = 12'h048;
  localparam logic [11:0] OFS_CHECK = 12'h04C;
  localparam logic [11:0] OFS_DATA = 12'h080;
  localparam logic [11:0] OFS_RING = 12'h100;
  localparam logic [11:0] OFS_RING_END = 12'h140;

  // ------------------------------------------------------------
  // Control, priority and window B control register fields
  // ------------------------------------------------------------
  localparam int CTL_SW_START = 0;
  localparam int CTL_GROUP = 1;
  localparam int CTL_DOUBLE = 2;
  localparam int CTL_SPEED = 3;
  localparam int CTL_AUTO_CLR = 4;
  localparam int CTL_MEAN = 5;
  localparam int CTL_SUM_CNT = 6;
  localparam int CTL_TEMP_SUM = 9;
  localparam int CTL_REF_SUM = 10;
  localparam int CTL_CHK_EN = 11;
  localparam int CTL_CHK_MODE = 12;
  localparam int CTL_CHK_LVL = 13;
  localparam int CTL_TRIG_A = 15;
  localparam int CTL_TRIG_B = 21;
  localparam int CTL_DUP_CH = 27;
  localparam int PRIO_EN = 0;
  localparam int PRIO_RESCAN = 1;
  localparam int WB_EN = 5;

  // ------------------------------------------------------------
  // Reset values, channel codes, sizes and bus transfer code
  // ------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] LEVEL_RESET = 16'h0000;
  localparam logic [4:0] CH_TEMP = 5'h18;
  localparam logic [4:0] CH_REF = 5'h19;
  localparam logic [4:0] CH_CHECK = 5'h1A;
  localparam int MAX_ANALOG = 24;
  localparam int RING_DEPTH = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_WAIT = 2'h3,
    ST_STORE = 2'h2
  } asc_state_t;

endpackage : asc_pkg

// ---- design/asc_scan_ctrl.sv ----
module asc_scan_ctrl import asc_pkg::*; #(
  parameter int NCH = 24,
  parameter int NTRIG = 64
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Start triggers from event linker and timers
  input wire logic [NTRIG-1:0] trig_in,
  // Analog conversion core
  output logic conv_start,
  output logic [4:0] conv_channel,
  output logic conv_low_current,
  output logic conv_check_mode,
  output logic [1:0] conv_check_level,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  // Interrupt requests and event linker outputs
  output logic scan_end_irq,
  output logic group_b_scan_end_irq,
  output logic evt_scan_end_nonb,
  output logic evt_group_b_end,
  output logic evt_all_end,
  output logic evt_window
);

  if (NCH < 1 || NCH > MAX_ANALOG) begin : g_bad_nch
    $error("NCH must be 1 to 24");
  end
  if (NTRIG < 1 || NTRIG > 64) begin : g_bad_ntrig
    $error("NTRIG must be 1 to 64");
  end

  // ----------------------------------------------------------
  // Storage
  // ----------------------------------------------------------
  logic [31:0] ctrl_reg, sel_a_reg, sel_b_reg, sum_sel_reg;
  logic [1:0] prio_reg;
  logic [31:0] wa_sel_reg, wa_cond_reg, wa_stat_reg;
  logic [15:0] wa_low_reg, wa_up_reg, wb_low_reg, wb_up_reg;
  logic [5:0] wb_ctrl_reg;
  logic wb_stat_reg, ring_en_reg;
  logic [3:0] ring_ptr_reg;
  logic [15:0] dup_reg, check_reg;
  logic [15:0] data_mem [0:31];
  logic [15:0] ring_mem [0:RING_DEPTH-1];
  asc_state_t state_reg;
  logic [31:0] remain_reg;
  logic [4:0] ch_reg;
  logic [2:0] rep_reg;
  logic [15:0] acc_reg;
  logic is_b_reg, second_reg, pend_b_reg;
  logic ph_act_reg, ph_wr_reg;
  logic [11:0] ph_addr_reg;

  function automatic logic [4:0] lsb_idx(input logic [31:0] m);
    lsb_idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (m[i]) lsb_idx = 5'(i);
    end
  endfunction : lsb_idx

  // ----------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------
  logic accept, wr_en, rd_en, data_hit, ring_hit;
  logic [31:0] rd_mux;
  assign accept = hsel && (htrans == HTRANS_NONSEQ) && hready;
  assign wr_en = ph_act_reg && ph_wr_reg;
  assign rd_en = ph_act_reg && !ph_wr_reg;
  assign data_hit = (ph_addr_reg >= OFS_DATA) && (ph_addr_reg < OFS_RING);
  assign ring_hit = (ph_addr_reg >= OFS_RING) &&
                    (ph_addr_reg < OFS_RING_END);

  // Every transfer gets one wait state, so reads see prior writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_act_reg <= 1'b0;
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 12'h000;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else if (accept) begin
      ph_act_reg <= 1'b1;
      ph_wr_reg <= hwrite;
      ph_addr_reg <= {haddr[11:2], 2'h0};
      hreadyout <= 1'b0;
    end else if (ph_act_reg) begin
      ph_act_reg <= 1'b0;
      hreadyout <= 1'b1;
      if (!ph_wr_reg) hrdata <= rd_mux;
    end
  end

  // Read decode; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ph_addr_reg == OFS_CTRL) rd_mux = ctrl_reg;
    else if (ph_addr_reg == OFS_SEL_A) rd_mux = sel_a_reg;
    else if (ph_addr_reg == OFS_SEL_B) rd_mux = sel_b_reg;
    else if (ph_addr_reg == OFS_SUM_SEL) rd_mux = sum_sel_reg;
    else if (ph_addr_reg == OFS_PRIO) rd_mux = {30'h0, prio_reg};
    else if (ph_addr_reg == OFS_STATUS)
      rd_mux = {27'h0, pend_b_reg, second_reg, is_b_reg, state_reg};
    else if (ph_addr_reg == OFS_WA_SEL) rd_mux = wa_sel_reg;
    else if (ph_addr_reg == OFS_WA_COND) rd_mux = wa_cond_reg;
    else if (ph_addr_reg == OFS_WA_LOW) rd_mux = {16'h0, wa_low_reg};
    else if (ph_addr_reg == OFS_WA_UP) rd_mux = {16'h0, wa_up_reg};
    else if (ph_addr_reg == OFS_WA_STAT) rd_mux = wa_stat_reg;
    else if (ph_addr_reg == OFS_WB_CTRL) rd_mux = {26'h0, wb_ctrl_reg};
    else if (ph_addr_reg == OFS_WB_LOW) rd_mux = {16'h0, wb_low_reg};
    else if (ph_addr_reg == OFS_WB_UP) rd_mux = {16'h0, wb_up_reg};
    else if (ph_addr_reg == OFS_WB_STAT) rd_mux = {31'h0, wb_stat_reg};
    else if (ph_addr_reg == OFS_WIN_MON)
      rd_mux = {30'h0, wb_stat_reg, |wa_stat_reg};
    else if (ph_addr_reg == OFS_RING_EN) rd_mux = {31'h0, ring_en_reg};
    else if (ph_addr_reg == OFS_RING_PTR) rd_mux = {28'h0, ring_ptr_reg};
    else if (ph_addr_reg == OFS_DUP) rd_mux = {16'h0, dup_reg};
    else if (ph_addr_reg == OFS_CHECK) rd_mux = {16'h0, check_reg};
    else if (data_hit) rd_mux = {16'h0, data_mem[ph_addr_reg[6:2]]};
    else if (ring_hit) rd_mux = {16'h0, ring_mem[ph_addr_reg[5:2]]};
  end

  // ----------------------------------------------------------
  // Scan control decode
  // ----------------------------------------------------------
  logic grp, dbl, sw_start, trig_a, trig_b, go_a, abort_b;
  logic sum_on, last_rep, store, fin, hit_a, hit_b;
  logic [31:0] mask_a, ana_mask;
  logic [4:0] dup_ch, nxt_ch;
  logic [2:0] sum_cnt;
  logic [15:0] value;
  assign grp = ctrl_reg[CTL_GROUP];
  assign dbl = ctrl_reg[CTL_DOUBLE];
  assign dup_ch = ctrl_reg[CTL_DUP_CH +: 5];
  assign sum_cnt = ctrl_reg[CTL_SUM_CNT +: 3];
  assign sw_start = wr_en && (ph_addr_reg == OFS_CTRL) &&
                    hwdata[CTL_SW_START];
  assign trig_a = trig_in[ctrl_reg[CTL_TRIG_A +: 6]];
  assign trig_b = grp && trig_in[ctrl_reg[CTL_TRIG_B +: 6]];
  assign go_a = sw_start || trig_a;
  assign abort_b = go_a && grp && is_b_reg && prio_reg[PRIO_EN] &&
                   (state_reg != ST_IDLE);
  assign ana_mask = (32'h1 << NCH) - 32'h1;
  // Double mode scans the duplicated channel alone
  assign mask_a = dbl ? (32'h1 << dup_ch) :
                  ((sel_a_reg & (ana_mask | 32'h0300_0000)) |
                   {5'h0, ctrl_reg[CTL_CHK_EN], 26'h0});
  assign nxt_ch = lsb_idx(remain_reg);
  // Temperature and reference channels have their own sum bits
  assign sum_on = (ch_reg == CH_TEMP) ? ctrl_reg[CTL_TEMP_SUM] :
                  (ch_reg == CH_REF) ? ctrl_reg[CTL_REF_SUM] :
                  (ch_reg < CH_TEMP) && sum_sel_reg[ch_reg];
  assign last_rep = !sum_on || (rep_reg == sum_cnt);
  assign store = (state_reg == ST_STORE);
  assign fin = store && (remain_reg == 32'h0);
  // Mean divides by the count when it is a power of two
  always_comb begin
    value = acc_reg;
    if (ctrl_reg[CTL_MEAN] && sum_on) begin
      if (sum_cnt == 3'h1) value = acc_reg >> 1;
      else if (sum_cnt == 3'h3) value = acc_reg >> 2;
      else if (sum_cnt == 3'h7) value = acc_reg >> 3;
    end
  end
  // Window A in-range match versus per-channel condition bit
  assign hit_a = store && wa_sel_reg[ch_reg] &&
                 (((value >= wa_low_reg) && (value <= wa_up_reg)) ==
                  wa_cond_reg[ch_reg]);
  assign hit_b = store && wb_ctrl_reg[WB_EN] &&
                 (ch_reg == wb_ctrl_reg[4:0]) &&
                 (value >= wb_low_reg) && (value <= wb_up_reg);

  // ----------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      remain_reg <= 32'h0;
      ch_reg <= 5'h00;
      rep_reg <= 3'h0;
      acc_reg <= 16'h0000;
      is_b_reg <= 1'b0;
      pend_b_reg <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 5'h00;
    end else begin
      conv_start <= 1'b0;
      if (abort_b) begin
        // Group A preempts group B, B may be rerun
        state_reg <= ST_START;
        ch_reg <= lsb_idx(mask_a);
        remain_reg <= mask_a & ~(32'h1 << lsb_idx(mask_a));
        rep_reg <= 3'h0;
        acc_reg <= 16'h0000;
        is_b_reg <= 1'b0;
        pend_b_reg <= prio_reg[PRIO_RESCAN];
      end else begin
        if (trig_b && state_reg != ST_IDLE) pend_b_reg <= 1'b1;
        case (state_reg)
          ST_IDLE: begin
            if (go_a && mask_a != 32'h0) begin
              state_reg <= ST_START;
              ch_reg <= lsb_idx(mask_a);
              remain_reg <= mask_a & ~(32'h1 << lsb_idx(mask_a));
              is_b_reg <= 1'b0;
            end else if ((trig_b || pend_b_reg) && sel_b_reg != 32'h0) begin
              state_reg <= ST_START;
              ch_reg <= lsb_idx(sel_b_reg);
              remain_reg <= sel_b_reg & ~(32'h1 << lsb_idx(sel_b_reg));
              is_b_reg <= 1'b1;
              pend_b_reg <= 1'b0;
            end
            rep_reg <= 3'h0;
            acc_reg <= 16'h0000;
          end
          ST_START: begin
            conv_start <= 1'b1;
            conv_channel <= ch_reg;
            state_reg <= ST_WAIT;
          end
          ST_WAIT: begin
            if (conv_done) begin
              acc_reg <= acc_reg + {4'h0, conv_result};
              if (last_rep) begin
                state_reg <= ST_STORE;
              end else begin
                rep_reg <= rep_reg + 3'h1;
                state_reg <= ST_START;
              end
            end
          end
          ST_STORE: begin
            rep_reg <= 3'h0;
            acc_reg <= 16'h0000;
            if (remain_reg == 32'h0) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_START;
              ch_reg <= nxt_ch;
              remain_reg <= remain_reg & ~(32'h1 << nxt_ch);
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // Result storage, auto clear on read
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 32; i++) data_mem[i] <= 16'h0000;
      dup_reg <= 16'h0000;
      check_reg <= 16'h0000;
    end else begin
      if (rd_en && data_hit && ctrl_reg[CTL_AUTO_CLR])
        data_mem[ph_addr_reg[6:2]] <= 16'h0000;
      if (rd_en && ph_addr_reg == OFS_DUP && ctrl_reg[CTL_AUTO_CLR])
        dup_reg <= 16'h0000;
      if (store) begin
        if (ch_reg == CH_CHECK) check_reg <= value;
        else if (dbl && second_reg && !is_b_reg && ch_reg == dup_ch)
          dup_reg <= value;
        else data_mem[ch_reg] <= value;
      end
    end
  end

  // ----------------------------------------------------------
  // Ring buffer
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_ptr_reg <= 4'h0;
      for (int i = 0; i < RING_DEPTH; i++) ring_mem[i] <= 16'h0000;
    end else if (wr_en && ph_addr_reg == OFS_RING_EN) begin
      ring_ptr_reg <= 4'h0;
    end else if (store && ring_en_reg) begin
      ring_mem[ring_ptr_reg] <= value;
      ring_ptr_reg <= ring_ptr_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------
  // Software registers; window status set wins over clear
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET;
      sel_a_reg <= 32'h0;
      sel_b_reg <= 32'h0;
      sum_sel_reg <= 32'h0;
      prio_reg <= 2'h0;
      wa_sel_reg <= 32'h0;
      wa_cond_reg <= 32'h0;
      wa_low_reg <= LEVEL_RESET;
      wa_up_reg <= LEVEL_RESET;
      wb_ctrl_reg <= 6'h00;
      wb_low_reg <= LEVEL_RESET;
      wb_up_reg <= LEVEL_RESET;
      ring_en_reg <= 1'b0;
      wa_stat_reg <= 32'h0;
      wb_stat_reg <= 1'b0;
    end else begin
      if (wr_en) begin
        if (ph_addr_reg == OFS_CTRL)
          ctrl_reg <= hwdata & ~(32'h1 << CTL_SW_START);
        else if (ph_addr_reg == OFS_SEL_A) sel_a_reg <= hwdata;
        else if (ph_addr_reg == OFS_SEL_B) sel_b_reg <= hwdata & ana_mask;
        else if (ph_addr_reg == OFS_SUM_SEL) sum_sel_reg <= hwdata;
        else if (ph_addr_reg == OFS_PRIO) prio_reg <= hwdata[1:0];
        else if (ph_addr_reg == OFS_WA_SEL) wa_sel_reg <= hwdata;
        else if (ph_addr_reg == OFS_WA_COND) wa_cond_reg <= hwdata;
        else if (ph_addr_reg == OFS_WA_LOW) wa_low_reg <= hwdata[15:0];
        else if (ph_addr_reg == OFS_WA_UP) wa_up_reg <= hwdata[15:0];
        else if (ph_addr_reg == OFS_WB_CTRL) wb_ctrl_reg <= hwdata[5:0];
        else if (ph_addr_reg == OFS_WB_LOW) wb_low_reg <= hwdata[15:0];
        else if (ph_addr_reg == OFS_WB_UP) wb_up_reg <= hwdata[15:0];
        else if (ph_addr_reg == OFS_RING_EN) ring_en_reg <= hwdata[0];
      end
      wa_stat_reg <= (wa_stat_reg &
        ~((wr_en && ph_addr_reg == OFS_WA_STAT) ? hwdata : 32'h0)) |
        (hit_a ? (32'h1 << ch_reg) : 32'h0);
      wb_stat_reg <= hit_b || (wb_stat_reg &&
        !(wr_en && ph_addr_reg == OFS_WB_STAT && hwdata[0]));
    end
  end

  // ----------------------------------------------------------
  // Requests, events and core settings
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_reg <= 1'b0;
      scan_end_irq <= 1'b0;
      group_b_scan_end_irq <= 1'b0;
      evt_scan_end_nonb <= 1'b0;
      evt_group_b_end <= 1'b0;
      evt_all_end <= 1'b0;
      evt_window <= 1'b0;
      conv_low_current <= 1'b0;
      conv_check_mode <= 1'b0;
      conv_check_level <= 2'h0;
    end else begin
      if (!dbl) second_reg <= 1'b0;
      else if (fin && !is_b_reg) second_reg <= !second_reg;
      scan_end_irq <= fin && !is_b_reg &&
                      (!dbl || second_reg);
      group_b_scan_end_irq <= fin && is_b_reg;
      evt_scan_end_nonb <= fin && grp && !is_b_reg;
      evt_group_b_end <= fin && grp && is_b_reg;
      evt_all_end <= fin;
      evt_window <= !grp && (hit_a || hit_b);
      conv_low_current <= ctrl_reg[CTL_SPEED];
      conv_check_mode <= ctrl_reg[CTL_CHK_MODE];
      conv_check_level <= ctrl_reg[CTL_CHK_LVL +: 2];
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_taken; accept; endsequence
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  a_bus_one_wait: assert property (s_taken |=> s_one_wait)
    else $error("bus wait state wrong");
  a_irq_plain: assert property (fin && !is_b_reg && !dbl |=>
    scan_end_irq) else $error("single scan irq missing");
  a_irq_double_first: assert property (
    fin && !is_b_reg && dbl && !second_reg |=> !scan_end_irq)
    else $error("irq after first double scan");
  a_group_b_irq: assert property (fin && is_b_reg |=>
    group_b_scan_end_irq && !scan_end_irq) else $error("B irq wrong");
  a_all_end_evt: assert property (fin |=> evt_all_end)
    else $error("all end event missing");
  a_nonb_evt: assert property (evt_scan_end_nonb |->
    $past(grp) && !$past(is_b_reg)) else $error("non-B event wrong");
  a_ring_advance: assert property (store && ring_en_reg &&
    !wr_en |=> ring_ptr_reg == $past(ring_ptr_reg) + 4'h1)
    else $error("ring pointer not advanced");
  a_auto_clear: assert property (rd_en && data_hit &&
    ctrl_reg[CTL_AUTO_CLR] && !store |=>
    data_mem[$past(ph_addr_reg[6:2])] == 16'h0000)
    else $error("data not cleared on read");
  a_prio_abort: assert property (abort_b |=>
    !is_b_reg && state_reg == ST_START ##1 conv_start)
    else $error("group A did not preempt B");

endmodule : asc_scan_ctrl

// ---- tb/asc_core_model.sv ----
module asc_core_model import asc_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Conversion handshake
  input wire logic conv_start,
  input wire logic [4:0] conv_channel,
  output logic conv_done,
  output logic [11:0] conv_result,
  // Answer speed and trigger sources
  input wire logic slow,
  input wire logic [5:0] trig_idx,
  input wire logic trig_go,
  output logic [63:0] trig_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  logic busy;
  logic [4:0] ch_reg;

  // Core: a new request abandons the old one; result flips when not valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      wait_cnt <= 0;
      conv_done <= 1'b0;
      conv_result <= 12'hA5A;
      ch_reg <= 5'h00;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        busy <= 1'b1;
        wait_cnt <= slow ? 20 : 1;
        ch_reg <= conv_channel;
      end else if (busy && wait_cnt == 0) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_result <= 12'h300 | 12'(ch_reg);
      end else if (busy) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end

  // Trigger sources: one-cycle start request on the chosen line
  always_ff @(posedge hclk) begin
    trig_in <= trig_go ? (64'h1 << trig_idx) : 64'h0;
  end
endmodule : asc_core_model

// ---- tb/test_adc_scan_control.sv ----
module test_adc_scan_control import asc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, conv_start, conv_low_current, conv_check_mode;
  logic [4:0] conv_channel;
  logic [1:0] conv_check_level;
  logic conv_done, slow = 1'b0, trig_go = 1'b0;
  logic [11:0] conv_result;
  logic [5:0] trig_idx = 6'h00;
  logic [63:0] trig_in;
  logic scan_end_irq, group_b_scan_end_irq, evt_scan_end_nonb;
  logic evt_group_b_end, evt_all_end, evt_window;
  int fail_count = 0, n_tests = 0, s[6];
  int n_irq = 0, n_irqb = 0, n_nonb = 0, n_b = 0, n_all = 0, n_win = 0;
  logic [4:0] chq[$];

  asc_scan_ctrl asc_scan_ctrl_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .trig_in(trig_in), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_low_current(conv_low_current),
    .conv_check_mode(conv_check_mode),
    .conv_check_level(conv_check_level), .conv_done(conv_done),
    .conv_result(conv_result), .scan_end_irq(scan_end_irq),
    .group_b_scan_end_irq(group_b_scan_end_irq),
    .evt_scan_end_nonb(evt_scan_end_nonb),
    .evt_group_b_end(evt_group_b_end), .evt_all_end(evt_all_end),
    .evt_window(evt_window));
  asc_core_model asc_core_model_i (.hclk(hclk), .hresetn(hresetn),
    .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_result(conv_result), .slow(slow),
    .trig_idx(trig_idx), .trig_go(trig_go), .trig_in(trig_in));

  // Clock and pulse counters on the event outputs
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    n_irq <= n_irq + int'(scan_end_irq === 1'b1);
    n_irqb <= n_irqb + int'(group_b_scan_end_irq === 1'b1);
    n_nonb <= n_nonb + int'(evt_scan_end_nonb === 1'b1);
    n_b <= n_b + int'(evt_group_b_end === 1'b1);
    n_all <= n_all + int'(evt_all_end === 1'b1);
    n_win <= n_win + int'(evt_window === 1'b1);
    if (conv_start === 1'b1) chq.push_back(conv_channel);
  end

  // ------------------------------------------------------------
  // Bus, scan and compare tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    check($sformatf("reg %h", a), x, exp);
  endtask : rdc
  task automatic wait_end(input int c);
    repeat (400) begin
      @(posedge hclk);
      if (n_all != c) break;
    end
    repeat (4) @(posedge hclk);
  endtask : wait_end
  task automatic go(input logic [31:0] ctrl);
    int c;
    c = n_all;
    wr(OFS_CTRL, ctrl); // Mode settles before the start strobe
    wr(OFS_CTRL, ctrl | 32'h1);
    wait_end(c);
  endtask : go
  task automatic fire(input logic [5:0] idx);
    int c;
    c = n_all;
    trig_idx <= idx;
    trig_go <= 1'b1;
    @(posedge hclk);
    trig_go <= 1'b0;
    wait_end(c);
  endtask : fire
  task automatic snap;
    s = '{n_irq, n_irqb, n_nonb, n_b, n_all, n_win};
  endtask : snap
  task automatic ev_chk(input int e0, e1, e2, e3, e4, e5);
    int cur[6];
    int e[6];
    cur = '{n_irq, n_irqb, n_nonb, n_b, n_all, n_win};
    e = '{e0, e1, e2, e3, e4, e5};
    for (int i = 0; i < 6; i++) begin
      check($sformatf("event %0d", i), 32'(cur[i] - s[i]), 32'(e[i]));
    end
  endtask : ev_chk
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // Watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(OFS_CTRL, 32'h0);
    rdc(12'h050, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    wr(OFS_CTRL, 32'h0000_5008);
    @(posedge hclk);
    check("core cfg", {28'h0, conv_check_mode, conv_check_level,
      conv_low_current}, 32'hD);
    wr(OFS_CTRL, 32'h0);
    @(posedge hclk);
    check("core cfg", {28'h0, conv_check_mode, conv_check_level,
      conv_low_current}, 32'h0);
    wr(OFS_SEL_A, 32'h5);
    wr(OFS_WA_SEL, 32'h1);
    wr(OFS_WA_COND, 32'h1);
    wr(OFS_WA_UP, 32'hFFF);
    chq.delete();
    snap();
    go(32'h0);
    ev_chk(1, 0, 0, 0, 1, 1);
    check("order", {chq[0], chq[1], 5'(chq.size())}, 15'h0042);
    rdc(OFS_DATA, 32'h300);
    rdc(OFS_DATA + 12'h8, 32'h302);
    rdc(OFS_WA_STAT, 32'h1);
    rdc(OFS_WIN_MON, 32'h1);
    wr(OFS_RING_EN, 32'h1);
    slow <= 1'b1;
    go(32'h10);
    slow <= 1'b0;
    rdc(OFS_DATA, 32'h300);
    rdc(OFS_DATA, 32'h0);
    rdc(OFS_RING + 12'h4, 32'h302);
    rdc(OFS_RING_PTR, 32'h2);
    wr(OFS_RING_EN, 32'h0);
    wr(OFS_SUM_SEL, 32'h1);
    go(32'h40);
    rdc(OFS_DATA, 32'h600);
    rdc(OFS_DATA + 12'h8, 32'h302);
    go(32'h60);
    rdc(OFS_DATA, 32'h300);
    go(32'h1C0);
    rdc(OFS_DATA, 32'h1800);
    wr(OFS_SEL_A, 32'h0100_0000);
    go(32'h40);
    rdc(OFS_DATA + 12'h60, 32'h318);
    go(32'h240);
    rdc(OFS_DATA + 12'h60, 32'h630);
    wr(OFS_SEL_A, 32'h0200_0000);
    go(32'h440);
    rdc(OFS_DATA + 12'h64, 32'h632);
    go(32'h800);
    rdc(OFS_CHECK, 32'h31A);
    wr(OFS_SUM_SEL, 32'h0);
    snap();
    go(32'h2800_0004);
    ev_chk(0, 0, 0, 0, 1, 0);
    go(32'h2800_0004);
    ev_chk(1, 0, 0, 0, 2, 0);
    rdc(OFS_DATA + 12'h14, 32'h305);
    rdc(OFS_DUP, 32'h305);
    wr(OFS_SEL_A, 32'h2);
    wr(OFS_SEL_B, 32'h10);
    wr(OFS_CTRL, 32'h00E1_8002);
    snap();
    fire(6'd3);
    ev_chk(1, 0, 1, 0, 1, 0);
    fire(6'd7);
    ev_chk(1, 1, 1, 1, 2, 0);
    fire(6'd4);
    ev_chk(1, 1, 1, 1, 2, 0);
    rdc(OFS_DATA + 12'h4, 32'h301);
    rdc(OFS_DATA + 12'h10, 32'h304);
    wr(OFS_CTRL, 32'h28E1_8006);
    snap();
    fire(6'd3);
    ev_chk(0, 0, 1, 0, 1, 0);
    fire(6'd3);
    ev_chk(1, 0, 2, 0, 2, 0);
    // Group A trigger lands mid B scan, B is rerun afterwards
    wr(OFS_CTRL, 32'h00E1_8002);
    wr(OFS_PRIO, 32'h3);
    slow <= 1'b1;
    snap();
    trig_idx <= 6'd7;
    trig_go <= 1'b1;
    @(posedge hclk);
    trig_go <= 1'b0;
    repeat (10) @(posedge hclk);
    fire(6'd3);
    wait_end(n_all);
    slow <= 1'b0;
    ev_chk(1, 1, 1, 1, 2, 0);
    complete_run();
  end
endmodule : test_adc_scan_control
